/* design/hbf_resp_sel.sv */
`timescale 1ns/10ps
module hbf_resp_sel
  import hbf_pkg::*;
#(
  parameter int          ADDR_W        = 12,
  parameter int unsigned HICCUP_CYCLES = HICCUP_CYC
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Protection comparator levels, high while fault present
  input  wire logic              hvb_out_uv,
  input  wire logic              hvb_in_ov,
  input  wire logic              hvb_in_uv,
  // Enable pins and strapped mode
  input  wire logic              pwm_en,
  input  wire logic              chip_en,
  input  wire logic [1:0]        mode_strap,
  // Open-drain fault flag
  input  wire logic              fault_flag_n_i,
  output logic                   fault_flag_n_o,
  output logic                   fault_flag_n_oe,
  // Switching permission to the modulator
  output logic                   pwm_run
);

  typedef struct packed {
    logic [SYN_W-1:0] s1;
    logic [SYN_W-1:0] s2;
    logic [SYN_W-1:0] s3;
    logic [SYN_W-1:0] clean;
    logic [1:0]       strap_cnt;
    logic             strap_done;
    logic [1:0]       mode;
    logic [7:0]       ind_en;
    logic [7:0]       resp_ctrl;
    logic [2:0]       stat;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             pwm_run;
    logic             flag_oe;
    logic             flag_o;
  } hbf_state_t;

  hbf_state_t cur_ff;
  hbf_state_t nxt_cur;

  // Channel wiring
  logic [N_FAULT-1:0] ch_stop_next;
  logic [N_FAULT-1:0] ch_stopped;
  logic [N_FAULT-1:0] ch_latched;
  logic [1:0]         eff_resp [N_FAULT];
  logic               release_req;
  logic [SYN_W-1:0]   pins;

  // Map flag-only alias onto the plain flag-only code
  function automatic logic [1:0] norm_resp(input logic [1:0] code);
    if (code == RESP_FLAG2) begin
      return RESP_FLAG;
    end
    return code;
  endfunction : norm_resp

  // Word address match for one register index
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [7:0]        idx);
    return a == ADDR_W'({idx, 2'b00});
  endfunction : reg_hit

  // Any mapped register
  function automatic logic any_hit(input logic [ADDR_W-1:0] a);
    return reg_hit(a, IDX_IND_EN) | reg_hit(a, IDX_RESP_CTRL) |
           reg_hit(a, IDX_FAULT_STAT) | reg_hit(a, IDX_BLK_STATE);
  endfunction : any_hit

  // Raw pin vector for the synchroniser
  assign pins = {mode_strap, fault_flag_n_i, chip_en, pwm_en,
                 hvb_in_uv, hvb_in_ov, hvb_out_uv};

  // Enable pin low is the first half of a toggle; it clears latch-off
  assign release_req = ~cur_ff.clean[SYN_PWM_EN] | ~cur_ff.clean[SYN_CHIP_EN];

  // Pick register field or strapped mode for each fault
  always_comb begin
    for (int i = 0; i < N_FAULT; i++) begin
      if (cur_ff.ind_en[IND_EN_BIT]) begin
        eff_resp[i] = norm_resp(cur_ff.resp_ctrl[RESP_FIELD_LSB + 2*i +: 2]);
      end else begin
        eff_resp[i] = norm_resp(cur_ff.mode);
      end
    end
  end

  // One sequencer per fault
  for (genvar g = 0; g < N_FAULT; g++) begin : g_chan
    hbf_fault_chan #(
      .HICCUP_CYCLES (HICCUP_CYCLES),
      .CW            (CNT_W)
    ) u_chan (
      .pclk        (pclk),
      .presetn     (presetn),
      .fault_lvl   (cur_ff.clean[SYN_FAULT_LSB + g]),
      .resp        (eff_resp[g]),
      .release_req (release_req),
      .stop_next   (ch_stop_next[g]),
      .stopped     (ch_stopped[g]),
      .latched     (ch_latched[g])
    );
  end

  // Next-state logic
  always_comb begin
    logic       acc;
    logic       wr;
    logic       hit;
    logic [7:0] rd;
    nxt_cur = cur_ff;
    acc     = psel & penable & cur_ff.pready;
    hit     = any_hit(paddr);
    wr      = acc & pwrite & hit & pstrb[0];
    rd      = 8'h00;

    // Three-stage pin synchroniser; clean follows once stages two and three agree
    nxt_cur.s1    = pins;
    nxt_cur.s2    = cur_ff.s1;
    nxt_cur.s3    = cur_ff.s2;
    nxt_cur.clean = (cur_ff.s2 & cur_ff.s3) |
                    (cur_ff.clean & (cur_ff.s2 | cur_ff.s3));

    // Strap caught a few cycles after reset, once the chain has settled
    if (!cur_ff.strap_done) begin
      if (cur_ff.strap_cnt == STRAP_CAP_CYC) begin
        nxt_cur.strap_done = 1'b1;
        nxt_cur.mode       = nxt_cur.clean[SYN_MODE_LSB +: 2];
      end else begin
        nxt_cur.strap_cnt = cur_ff.strap_cnt + 2'h1;
      end
    end

    // Register writes on the access edge
    if (wr && reg_hit(paddr, IDX_IND_EN)) begin
      nxt_cur.ind_en = pwdata[7:0];
    end
    if (wr && reg_hit(paddr, IDX_RESP_CTRL)) begin
      nxt_cur.resp_ctrl = pwdata[7:0];
    end

    // Sticky status, write one to clear; a fault present wins over the clear
    for (int i = 0; i < N_FAULT; i++) begin
      if (wr && reg_hit(paddr, IDX_FAULT_STAT) && pwdata[STAT_FIELD_LSB + i]) begin
        nxt_cur.stat[i] = 1'b0;
      end
      if (cur_ff.clean[SYN_FAULT_LSB + i]) begin
        nxt_cur.stat[i] = 1'b1;
      end
    end

    // Flag pulled low while any status bit stands
    nxt_cur.flag_o  = 1'b0;
    nxt_cur.flag_oe = |nxt_cur.stat;

    // Switching stops on the same edge as the status; flag-only never stops it
    nxt_cur.pwm_run = cur_ff.clean[SYN_PWM_EN] & cur_ff.clean[SYN_CHIP_EN] &
                      ~|ch_stop_next;

    // Read mux
    if (reg_hit(paddr, IDX_IND_EN)) begin
      rd = cur_ff.ind_en;
    end else if (reg_hit(paddr, IDX_RESP_CTRL)) begin
      rd = cur_ff.resp_ctrl;
    end else if (reg_hit(paddr, IDX_FAULT_STAT)) begin
      rd = {cur_ff.stat, 5'h00};
    end else if (reg_hit(paddr, IDX_BLK_STATE)) begin
      rd = {cur_ff.clean[SYN_FLAG], ch_latched, ch_stopped, cur_ff.pwm_run};
    end

    // One wait state: ready rises in the second access cycle, then drops
    nxt_cur.pready  = psel & penable & ~cur_ff.pready;
    nxt_cur.pslverr = nxt_cur.pready & ~hit;
    if (nxt_cur.pready && !pwrite) begin
      nxt_cur.prdata = {24'h000000, rd};
    end else if (nxt_cur.pready) begin
      nxt_cur.prdata = 32'h00000000;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '{
        s1:         '0,
        s2:         '0,
        s3:         '0,
        clean:      '0,
        strap_cnt:  2'h0,
        strap_done: 1'b0,
        mode:       RESP_FLAG,
        ind_en:     IND_EN_RST,
        resp_ctrl:  RESP_CTRL_RST,
        stat:       3'h0,
        prdata:     32'h00000000,
        pready:     1'b0,
        pslverr:    1'b0,
        pwm_run:    1'b0,
        flag_oe:    1'b0,
        flag_o:     1'b0
      };
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Outputs straight from the state register
  assign pready          = cur_ff.pready;
  assign prdata          = cur_ff.prdata;
  assign pslverr         = cur_ff.pslverr;
  assign pwm_run         = cur_ff.pwm_run;
  assign fault_flag_n_o  = cur_ff.flag_o;
  assign fault_flag_n_oe = cur_ff.flag_oe;

endmodule : hbf_resp_sel

/* design/hbf_pkg.sv */
package hbf_pkg;

  // Clock rate and hiccup restart delay
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned CLK_PER_MS     = CLK_HZ / 1000;
  localparam int unsigned HICCUP_TIME_MS = 500;
  localparam int unsigned HICCUP_CYC     = CLK_PER_MS * HICCUP_TIME_MS;
  localparam int          CNT_W          = 24;

  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_IND_EN     = 8'hB0;
  localparam logic [7:0] IDX_RESP_CTRL  = 8'hB8;
  localparam logic [7:0] IDX_FAULT_STAT = 8'hD7;
  localparam logic [7:0] IDX_BLK_STATE  = 8'hE0;

  // Field positions
  localparam int IND_EN_BIT     = 7;
  localparam int RESP_FIELD_LSB = 2;
  localparam int STAT_FIELD_LSB = 5;
  localparam int N_FAULT        = 3;

  // Values after reset, and the strap capture count
  localparam logic [7:0] IND_EN_RST    = 8'h00;
  localparam logic [7:0] RESP_CTRL_RST = 8'h00;
  localparam logic [1:0] STRAP_CAP_CYC = 2'h3;

  // Response codes
  localparam logic [1:0] RESP_FLAG   = 2'h0;
  localparam logic [1:0] RESP_HICCUP = 2'h1;
  localparam logic [1:0] RESP_LATCH  = 2'h2;
  localparam logic [1:0] RESP_FLAG2  = 2'h3;

  // Positions inside the pin synchroniser vector
  localparam int SYN_FAULT_LSB = 0;
  localparam int SYN_PWM_EN    = 3;
  localparam int SYN_CHIP_EN   = 4;
  localparam int SYN_FLAG      = 5;
  localparam int SYN_MODE_LSB  = 6;
  localparam int SYN_W         = 8;

  // Per-fault response state
  typedef enum logic [3:0] {
    CH_RUN   = 4'h1,
    CH_HOLD  = 4'h2,
    CH_WAIT  = 4'h4,
    CH_LATCH = 4'h8
  } hbf_chan_st_t;

endpackage : hbf_pkg

/* design/hbf_fault_chan.sv */
`timescale 1ns/10ps
module hbf_fault_chan
  import hbf_pkg::*;
#(
  parameter int unsigned HICCUP_CYCLES = HICCUP_CYC,
  parameter int          CW            = CNT_W
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Fault level and selected response
  input  wire logic       fault_lvl,
  input  wire logic [1:0] resp,
  input  wire logic       release_req,
  // Switching state
  output logic            stop_next,
  output logic            stopped,
  output logic            latched
);

  typedef struct packed {
    hbf_chan_st_t   st;
    logic [CW-1:0]  cnt;
  } hbf_chan_s_t;

  localparam logic [CW-1:0] LAST = CW'(HICCUP_CYCLES - 1);

  hbf_chan_s_t cur_ff;
  hbf_chan_s_t nxt_cur;

  // Next state of the response sequencer
  always_comb begin
    nxt_cur = cur_ff;
    case (cur_ff.st)
      CH_RUN: begin
        if (fault_lvl && resp == RESP_HICCUP) begin
          nxt_cur.st = CH_HOLD;
        end else if (fault_lvl && resp == RESP_LATCH) begin
          nxt_cur.st = CH_LATCH;
        end
      end
      CH_HOLD: begin
        if (!fault_lvl) begin
          nxt_cur.st  = CH_WAIT;
          nxt_cur.cnt = '0;
        end
      end
      CH_WAIT: begin
        // Fault back before expiry restarts the wait
        if (fault_lvl) begin
          nxt_cur.st = CH_HOLD;
        end else if (cur_ff.cnt == LAST) begin
          nxt_cur.st = CH_RUN;
        end else begin
          nxt_cur.cnt = cur_ff.cnt + 1'b1;
        end
      end
      CH_LATCH: begin
        // Only an enable pin going low gets out of here
        if (release_req) begin
          nxt_cur.st = CH_RUN;
        end
      end
      default: begin
        nxt_cur.st = CH_RUN;
      end
    endcase
  end

  // Outputs; stop_next lets the top stop switching on the status edge
  assign stop_next = (nxt_cur.st != CH_RUN);
  assign stopped   = (cur_ff.st != CH_RUN);
  assign latched   = (cur_ff.st == CH_LATCH);

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '{st: CH_RUN, cnt: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

endmodule : hbf_fault_chan

/* verif/hbf_resp_sel_chk.sv */
`timescale 1ns/10ps
module hbf_resp_sel_chk
  import hbf_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // Register bus
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  // Pins
  input wire logic              hvb_out_uv,
  input wire logic              hvb_in_ov,
  input wire logic              hvb_in_uv,
  input wire logic              pwm_en,
  input wire logic              chip_en,
  input wire logic              fault_flag_n_o,
  input wire logic              fault_flag_n_oe,
  input wire logic              pwm_run
);
  // Any fault level, pins are far slower than the window used
  wire logic any_flt = hvb_out_uv | hvb_in_ov | hvb_in_uv;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bus handshake
  AST_ONE_WAIT: assert property ($rose(penable) && psel |=> pready)
    else $error("no answer after one wait state");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  AST_ERR_MAP: assert property (pready |->
    pslverr == !(paddr inside {12'h2C0, 12'h2E0, 12'h35C, 12'h380}))
    else $error("error response does not match address map");
  AST_RD_ZERO: assert property (pready && (pwrite || pslverr) |-> prdata == 32'h0)
    else $error("read data not zero");
  // Outputs after reset release
  AST_RST_QUIET: assert property ($rose(presetn) |-> !pready && !pwm_run && !fault_flag_n_oe)
    else $error("outputs active at reset release");
  // Flag pin, open drain
  AST_FLAG_LOW_ONLY: assert property (fault_flag_n_o == 1'b0)
    else $error("flag drives high");
  AST_FLAG_ON_FAULT: assert property (any_flt [*6] |-> fault_flag_n_oe)
    else $error("flag not pulled with fault present");
  // Flag only lets go after a completed register write
  AST_FLAG_STICKY: assert property (fault_flag_n_oe && !(pready && pwrite) |=> fault_flag_n_oe)
    else $error("flag released without a status write");
  // Switching stops only with a fault flagged or an enable pin low
  AST_STOP_WITH_FLAG: assert property ($fell(pwm_run) && pwm_en && chip_en
    && $past(pwm_en, 6) && $past(chip_en, 6) |-> fault_flag_n_oe)
    else $error("switching stopped without flag");
  AST_STOP_PWM_EN: assert property ((!pwm_en) [*6] |-> !pwm_run)
    else $error("switching with enable low");
  AST_STOP_CHIP_EN: assert property ((!chip_en) [*6] |-> !pwm_run)
    else $error("switching with chip enable low");
endmodule : hbf_resp_sel_chk

bind hbf_resp_sel hbf_resp_sel_chk #(.ADDR_W(ADDR_W)) hbf_resp_sel_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .hvb_out_uv(hvb_out_uv), .hvb_in_ov(hvb_in_ov), .hvb_in_uv(hvb_in_uv),
  .pwm_en(pwm_en), .chip_en(chip_en), .fault_flag_n_o(fault_flag_n_o),
  .fault_flag_n_oe(fault_flag_n_oe), .pwm_run(pwm_run));

/* verif/hbf_host.sv */
`timescale 1ns/10ps
module hbf_host #(
  parameter int ADDR_W = 12
) (
  // Clock
  input wire logic               pclk,
  // Bus requests
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic [ADDR_W-1:0]      paddr,
  output logic [31:0]            pwdata,
  output logic [3:0]             pstrb,
  // Bus answers
  input wire logic               pready,
  input wire logic [31:0]        prdata,
  input wire logic               pslverr
);
  // Idle bus
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
  end

  // One transfer, entered just after a rising edge; one idle edge after it
  task automatic xfer(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge pclk);
  endtask : xfer
endmodule : hbf_host

/* verif/hbf_resp_sel_bench.sv */
`timescale 1ns/10ps
module hbf_resp_sel_bench;
  import hbf_pkg::*;
  localparam int unsigned HIC = 20;
  logic        pclk, presetn, pwm_en, chip_en, psel, penable, pwrite, pready, pslverr, e;
  logic        flag_o, flag_oe, pwm_run;
  logic [2:0]  flt;
  logic [1:0]  mode_strap;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  int          miscompares = 0;
  int          tests_run = 0;
  // Pin level with its pull-up
  wire logic   flag_pin = flag_oe ? flag_o : 1'b1;

  hbf_resp_sel #(.HICCUP_CYCLES(HIC)) hbf_resp_sel_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .hvb_out_uv(flt[0]), .hvb_in_ov(flt[1]), .hvb_in_uv(flt[2]), .pwm_en(pwm_en),
    .chip_en(chip_en), .mode_strap(mode_strap), .fault_flag_n_i(flag_pin),
    .fault_flag_n_o(flag_o), .fault_flag_n_oe(flag_oe), .pwm_run(pwm_run));
  hbf_host hbf_host_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %0h expected %0h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    hbf_host_i.xfer(a, 1'b1, d, q, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    hbf_host_i.xfer(a, 1'b0, 32'h0, q, e);
    chk(q, x, "read data");
    chk(32'(e), 32'(xe), "error response");
  endtask : rd

  // Reset with a given strap; strap held well past its capture
  task automatic rst(input logic [1:0] s);
    presetn <= 1'b0;
    mode_strap <= s;
    wt(2);
    presetn <= 1'b1;
    wt(12);
  endtask : rst

  task automatic t_regs;
    rd(12'h2E0, 32'h0, 1'b0);
    rd(12'h2C0, 32'h0, 1'b0);
    wr(12'h2E0, 32'hE4);
    wr(12'h104, 32'hFF);
    rd(12'h2E0, 32'hE4, 1'b0);
    rd(12'h100, 32'h0, 1'b1);
  endtask : t_regs

  // Fault i with field value fld; eff is the response that should take effect
  task automatic t_fault(input int i, input logic [1:0] fld, input logic [1:0] eff);
    logic stop;
    stop = (eff == RESP_HICCUP) || (eff == RESP_LATCH);
    wr(12'h2E0, 32'(fld) << (2 * i + 2));
    flt[i] <= 1'b1;
    for (int k = 0; k < 8 && flag_oe !== 1'b1; k++) wt(1);
    chk(32'(flag_oe), 32'h1, "flag");
    chk(32'(pwm_run), 32'(!stop), "run with flag");
    rd(12'h35C, 32'h20 << i, 1'b0);
    // State word: synchronised flag pin level, channel latched, channel stopped, run bit
    rd(12'h380, {24'h0, 1'b0, (eff == RESP_LATCH) ? 3'(1 << i) : 3'h0,
                 stop ? 3'(1 << i) : 3'h0, !stop}, 1'b0);
    flt[i] <= 1'b0;
    // Fault returning mid-wait must restart the count
    if (eff == RESP_HICCUP) begin
      wt(12);
      flt[i] <= 1'b1;
      wt(6);
      flt[i] <= 1'b0;
      wt(15);
      chk(32'(pwm_run), 32'h0, "early restart");
    end
    wt(HIC + 10);
    chk(32'(pwm_run), 32'(eff != RESP_LATCH), "after clear");
    if (eff == RESP_LATCH) begin
      {pwm_en, chip_en} <= (i == 2) ? 2'b10 : 2'b01;
      wt(6);
      {pwm_en, chip_en} <= 2'b11;
      wt(8);
      chk(32'(pwm_run), 32'h1, "latch release");
    end
    wr(12'h35C, 32'h20 << i);
    wt(2);
    chk(32'(flag_oe), 32'h0, "flag clear");
  endtask : t_fault

  // Main sequence
  initial begin
    flt = 3'h0;
    pwm_en = 1'b1;
    chip_en = 1'b1;
    rst(RESP_FLAG);
    t_regs();
    t_fault(0, RESP_LATCH, RESP_FLAG);
    wr(12'h2C0, 32'h80);
    for (int i = 0; i < 3; i++)
      for (int c = 0; c < 4; c++) t_fault(i, 2'(c), 2'(c));
    rst(RESP_LATCH);
    t_fault(1, RESP_FLAG, RESP_LATCH);
    test_done();
  end

  // Watchdog
  initial begin
    wt(20000);
    miscompares++;
    $display("unexpected at %0t: run did not finish", $time);
    test_done();
  end
endmodule : hbf_resp_sel_bench
